// ---- scs_regs.sv ----
// system command and status register group behind the serial port
// assumes the serial clock idles high, data shifts out on its falling edge and
// is sampled on its rising edge; command side effects other than status clear and factory io register restore run in outside logic
//
// What this block does
// [RL1] command bits start their function on a one and self-clear when done
// [RL2] host writes bit 8 (word 0xBF01) to clear records; 25.9 ms
// [RL3] bit 13 restores a record from flash within 1.9 ms
// [RL4] bit 12 saves alarm band registers to flash in 461 us
// [RL5] bit 9 erases stored alarm bands from flash in 25.8 ms
// [RL6] bit 14 fetches alarm band selected by pointer within 40 us
// [RL7] bit 6 saves user registers to flash in 29.3 ms
// [RL8] bit 5 checks flash sum against reference, result in checksum flag; 5.6 ms
// [RL9] bit 3 restores factory registers and clears buffers; 80.9 ms
// [RL10] bit 2 runs self-test for 32.9 ms, result in status bit 5
// [RL11] error flags stick until clear command (0xBE10) or recording start
// [RL12] status bits 14 to 8 record alarm thresholds exceeded last recording
// [RL13] bit 14 system alarm, 13..11 Z Y X level two, 10..8 level one
// [RL14] status bit 3 sets when serial clock count is not a multiple of 16
// [RL15] status bit 7 reads zero while busy, one when data ready
// [RL16] status bit 6 holds checksum test result, set on failure
// [RL17] status bit 4 sets when escape command 0xE8 interrupts a recording
// [RL18] status bit 1 sets when supply exceeds 3.625 V
// [RL19] status bit 0 sets when supply falls below 3.125 V
// [RL20] status bit 15 reads zero; flags change only through their events
`timescale 1ns/1ps
`include "scs_cfg.svh"

module scs_regs #(
    parameter int unsigned       TW          = 25,
    parameter logic [15:0]       DIO_RESET   = 16'h0000,
    parameter logic [15:0]       GPIO_RESET  = 16'h0000,
    parameter int unsigned       CYC_RESTORE = `SCS_CYC(`SCS_T_RESTORE_NS),
    parameter int unsigned       CYC_ALMSAV  = `SCS_CYC(`SCS_T_ALMSAV_NS),
    parameter int unsigned       CYC_ALMERA  = `SCS_CYC(`SCS_T_ALMERA_NS),
    parameter int unsigned       CYC_CLRREC  = `SCS_CYC(`SCS_T_CLRREC_NS),
    parameter int unsigned       CYC_SWRST   = `SCS_CYC(`SCS_T_SWRST_NS),
    parameter int unsigned       CYC_SAVE    = `SCS_CYC(`SCS_T_SAVE_NS),
    parameter int unsigned       CYC_FTEST   = `SCS_CYC(`SCS_T_FTEST_NS),
    parameter int unsigned       CYC_FACT    = `SCS_CYC(`SCS_T_FACT_NS),
    parameter int unsigned       CYC_SELF    = `SCS_CYC(`SCS_T_SELF_NS),
    parameter int unsigned       CYC_AUTONUL = `SCS_CYC(`SCS_T_AUTONUL_NS)
) (
    // system clock, reset, freeze
    input  wire logic            i_clk,
    input  wire logic            i_rst_b,
    input  wire logic            i_ce,
    // serial port
    input  wire logic            i_sclk,
    input  wire logic            i_cs_b,
    input  wire logic            i_din,
    output logic                 o_dout,
    // recording, flash and measurement events
    input  wire logic            i_rec_active,
    input  wire logic            i_rec_start,
    input  wire logic [6:0]      i_alarm_hit,
    input  wire logic            i_checksum_fail,
    input  wire logic            i_selftest_fail,
    input  wire logic            i_flash_fail,
    input  wire logic            i_supply_high,
    input  wire logic            i_supply_low,
    // read-only contents held elsewhere
    input  wire logic [15:0]     i_flash_write_count,
    input  wire logic [15:0]     i_lot_code_one,
    input  wire logic [15:0]     i_lot_code_two,
    input  wire logic [15:0]     i_product_code,
    input  wire logic [15:0]     i_unit_serial,
    // command and register outputs
    output logic [15:0]          o_cmd_start,
    output logic                 o_rec_escape,
    output logic [15:0]          o_status,
    output logic [15:0]          o_digital_io_config,
    output logic [15:0]          o_general_io_control
);

    localparam int unsigned CYC_NULCLR = `SCS_CYC(`SCS_T_NULCLR_NS);
    localparam int unsigned CYC_ALMGET = `SCS_CYC(`SCS_T_ALMGET_NS);
    localparam int unsigned CYC_PTR    = `SCS_CYC(`SCS_T_PTR_NS);
    localparam int unsigned CYC_CLRST  = `SCS_CYC(`SCS_T_CLRST_NS);

    if (TW < 12 || CYC_AUTONUL >= (64'd1 << TW) || CYC_FACT >= (64'd1 << TW) ||
        CYC_RESTORE < 1 || CYC_ALMSAV < 1 || CYC_ALMERA < 1 || CYC_CLRREC < 1 ||
        CYC_SWRST < 1 || CYC_SAVE < 1 || CYC_FTEST < 1 || CYC_SELF < 1 ||
        CYC_AUTONUL < 1 || CYC_FACT < 1) begin : g_chk
        $error("scs_regs: timer width cannot hold the command times");
    end

    ////////////////////////////////////////////////////////////////////////////
    // link side, on the serial clock

    // the bit counter is cleared by the frame's own select so that a frame
    // never depends on a serial edge after its last one
    logic       lnk_clr;
    logic [3:0] bit_cnt_ff;
    logic [14:0] sh_ff;
    logic [15:0] rx_word_ff;
    logic       rx_tgl_ff;
    logic       partial_ff;
    logic [15:0] rd_word_ff;

    assign lnk_clr = i_cs_b | ~i_rst_b;

    always_ff @(posedge i_sclk or posedge lnk_clr) begin
        if (lnk_clr) begin
            bit_cnt_ff <= 4'h0;
        end else begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sh_ff      <= 15'h0000;
            rx_word_ff <= 16'h0000;
            rx_tgl_ff  <= 1'b0;
            partial_ff <= 1'b0;
        end else begin
            sh_ff      <= {sh_ff[13:0], i_din};
            // [RL14] track word boundary
            partial_ff <= (bit_cnt_ff != `SCS_W_LAST);
            if (bit_cnt_ff == `SCS_W_LAST) begin
                rx_word_ff <= {sh_ff, i_din};
                rx_tgl_ff  <= ~rx_tgl_ff;
            end
        end
    end

    // read data is quasi-static: it changes only a few system cycles after a
    // word arrives, long before the host may start the next word
    always_ff @(negedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_dout <= 1'b0;
        end else begin
            o_dout <= rd_word_ff[~bit_cnt_ff];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // crossings into the system clock

    logic cs_s1_ff, cs_s2_ff, cs_s3_ff, cs_s4_ff;
    logic tgl_s1_ff, tgl_s2_ff, tgl_s3_ff;
    logic part_s1_ff, part_s2_ff;
    logic word_evt;
    logic frame_bad;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cs_s1_ff   <= 1'b1;
            cs_s2_ff   <= 1'b1;
            cs_s3_ff   <= 1'b1;
            cs_s4_ff   <= 1'b1;
            tgl_s1_ff  <= 1'b0;
            tgl_s2_ff  <= 1'b0;
            tgl_s3_ff  <= 1'b0;
            part_s1_ff <= 1'b0;
            part_s2_ff <= 1'b0;
        end else if (i_ce) begin
            cs_s1_ff   <= i_cs_b;
            cs_s2_ff   <= cs_s1_ff;
            cs_s3_ff   <= cs_s2_ff;
            cs_s4_ff   <= cs_s3_ff;
            tgl_s1_ff  <= rx_tgl_ff;
            tgl_s2_ff  <= tgl_s1_ff;
            tgl_s3_ff  <= tgl_s2_ff;
            part_s1_ff <= partial_ff;
            part_s2_ff <= part_s1_ff;
        end
    end

    assign word_evt = tgl_s2_ff ^ tgl_s3_ff;
    // the select edge is taken one stage late so the boundary level has settled
    // [RL14] bad frame length
    assign frame_bad = cs_s3_ff & ~cs_s4_ff & part_s2_ff;

    ////////////////////////////////////////////////////////////////////////////
    // word decode

    logic [6:0] w_adr;
    logic       w_wr;
    logic       esc_evt;
    logic       cmd_wr;
    logic [15:0] cmd_bits;

    assign w_adr   = rx_word_ff[14:8];
    assign w_wr    = word_evt & rx_word_ff[`SCS_W_WR];
    // [RL17] escape during recording
    assign esc_evt = word_evt & (rx_word_ff[15:8] == `SCS_W_ESC) & i_rec_active;
    // [RL2] [RL11] command words
    assign cmd_wr  = w_wr & ((w_adr | 7'h01) == (`SCS_A_CMD | 7'h01));
    assign cmd_bits = w_adr[0] ? {rx_word_ff[7:0], 8'h00} : {8'h00, rx_word_ff[7:0]};
    ////////////////////////////////////////////////////////////////////////////
    // command engine, one command at a time, highest bit first

    scs_pkg::scs_state_t st_ff;
    logic [15:0]         pend_ff;
    logic [3:0]          cur_ff;
    logic [TW-1:0]       tmr_ff;
    logic                found;
    logic [3:0]          pick;
    logic                done;
    // [RL3] [RL4] [RL5] [RL6] [RL7] run lengths
    function automatic logic [TW-1:0] cmd_len(input logic [3:0] idx);
        case (idx)
            4'hF:    cmd_len = TW'(CYC_NULCLR);
            4'hE:    cmd_len = TW'(CYC_ALMGET);
            4'hD:    cmd_len = TW'(CYC_RESTORE);
            4'hC:    cmd_len = TW'(CYC_ALMSAV);
            4'hA:    cmd_len = TW'(CYC_PTR);
            4'h9:    cmd_len = TW'(CYC_ALMERA);
            4'h8:    cmd_len = TW'(CYC_CLRREC);
            4'h7:    cmd_len = TW'(CYC_SWRST);
            4'h6:    cmd_len = TW'(CYC_SAVE);
            4'h5:    cmd_len = TW'(CYC_FTEST);
            4'h4:    cmd_len = TW'(CYC_CLRST);
            4'h3:    cmd_len = TW'(CYC_FACT);
            4'h2:    cmd_len = TW'(CYC_SELF);
            4'h0:    cmd_len = TW'(CYC_AUTONUL);
            // record start/stop and power-down hand off at once
            default: cmd_len = TW'(1);
        endcase
    endfunction

    always_comb begin
        found = 1'b0;
        pick  = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (pend_ff[i]) begin
                found = 1'b1;
                pick  = 4'(i);
            end
        end
    end

    assign done = (st_ff == scs_pkg::SCS_RUN) & (tmr_ff == TW'(1));

    // [RL1] start, then self-clear
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_ff       <= scs_pkg::SCS_IDLE;
            pend_ff     <= 16'h0000;
            cur_ff      <= 4'h0;
            tmr_ff      <= '0;
            o_cmd_start <= 16'h0000;
        end else if (i_ce) begin
            o_cmd_start <= 16'h0000;
            unique case (st_ff)
                scs_pkg::SCS_IDLE: begin
                    // commands wait while the supply is outside its limits
                    if (found && !i_supply_high && !i_supply_low) begin
                        st_ff             <= scs_pkg::SCS_RUN;
                        cur_ff            <= pick;
                        tmr_ff            <= cmd_len(pick);
                        o_cmd_start[pick] <= 1'b1;
                    end
                end
                scs_pkg::SCS_RUN: begin
                    tmr_ff <= tmr_ff - TW'(1);
                    if (done) begin
                        st_ff <= scs_pkg::SCS_IDLE;
                    end
                end
            endcase
            // a write in the completion cycle keeps its bit pending
            pend_ff <= (pend_ff & ~(done ? (16'h0001 << cur_ff) : 16'h0000)) |
                       (cmd_wr ? cmd_bits : 16'h0000);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags

    logic        fin_self, fin_ftest, fin_clr, fin_fact;
    logic        busy;
    logic [15:0] set_bits;
    logic        clr_flags;

    assign fin_self  = done & (cur_ff == 4'(`SCS_C_SELF));
    assign fin_ftest = done & (cur_ff == 4'(`SCS_C_FTEST));
    assign fin_clr   = done & (cur_ff == 4'(`SCS_C_CLRST));
    assign fin_fact  = done & (cur_ff == 4'(`SCS_C_FACT));
    assign busy      = i_rec_active | (st_ff == scs_pkg::SCS_RUN) | (pend_ff != 16'h0000);
    // [RL11] sticky clear sources
    assign clr_flags = fin_clr | i_rec_start;

    always_comb begin
        set_bits = 16'h0000;
        // [RL12] [RL13] alarm flags in axis order
        set_bits[`SCS_S_ALM +: 7] = i_alarm_hit;
        // [RL8] [RL16] checksum result
        set_bits[`SCS_S_CHK]      = fin_ftest & i_checksum_fail;
        // [RL10] self-test result
        set_bits[`SCS_S_SELF]     = fin_self & i_selftest_fail;
        set_bits[`SCS_S_ESC]      = esc_evt;
        set_bits[`SCS_S_SPI]      = frame_bad;
        set_bits[`SCS_S_FLASH]    = i_flash_fail;
        // [RL18] [RL19] supply limits
        set_bits[`SCS_S_VHI]      = i_supply_high;
        set_bits[`SCS_S_VLO]      = i_supply_low;
    end

    // [RL20] only events, the clear command and recording start move flags
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_status <= 16'h0000;
        end else if (i_ce) begin
            o_status <= ((clr_flags ? 16'h0000 : o_status) | set_bits) &
                        ~(16'h0001 << `SCS_S_UNUSED) & ~(16'h0001 << `SCS_S_RDY);
            // [RL15] ready level
            o_status[`SCS_S_RDY] <= ~busy;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_rec_escape <= 1'b0;
        end else if (i_ce) begin
            o_rec_escape <= esc_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // writable configuration and read data

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_digital_io_config  <= DIO_RESET;
            o_general_io_control <= GPIO_RESET;
        end else if (i_ce) begin
            if (fin_fact) begin
                // [RL9] factory values
                o_digital_io_config  <= DIO_RESET;
                o_general_io_control <= GPIO_RESET;
            end else if (w_wr && !esc_evt) begin
                if (w_adr == `SCS_A_DIO) o_digital_io_config[7:0] <= rx_word_ff[7:0];
                if (w_adr == (`SCS_A_DIO | 7'h01)) begin
                    o_digital_io_config[15:8] <= rx_word_ff[7:0];
                end
                if (w_adr == `SCS_A_GPIO) o_general_io_control[7:0] <= rx_word_ff[7:0];
                if (w_adr == (`SCS_A_GPIO | 7'h01)) begin
                    o_general_io_control[15:8] <= rx_word_ff[7:0];
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rd_word_ff <= 16'h0000;
        end else if (i_ce && word_evt && !rx_word_ff[`SCS_W_WR]) begin
            unique case (w_adr & 7'h7E)
                `SCS_A_FLASH: rd_word_ff <= i_flash_write_count;
                `SCS_A_DIO:   rd_word_ff <= o_digital_io_config;
                `SCS_A_GPIO:  rd_word_ff <= o_general_io_control;
                `SCS_A_STAT:  rd_word_ff <= o_status;
                `SCS_A_LOT1:  rd_word_ff <= i_lot_code_one;
                `SCS_A_LOT2:  rd_word_ff <= i_lot_code_two;
                `SCS_A_PROD:  rd_word_ff <= i_product_code;
                `SCS_A_SER:   rd_word_ff <= i_unit_serial;
                // command register is write-only; unmapped reads as zero
                default:      rd_word_ff <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b || !i_ce);
    unused_bit_a: assert property (o_status[15] == 1'b0) // [RL20]
        else $error("unused status bit set");
    busy_ready_a: assert property ((st_ff == scs_pkg::SCS_RUN) |=> !o_status[7]) // [RL15]
        else $error("ready shown while a command runs");
    self_clear_a: assert property ((done && !cmd_wr) |=> // [RL1]
        (st_ff == scs_pkg::SCS_IDLE) && !pend_ff[$past(cur_ff)])
        else $error("command bit not cleared at completion");
    start_one_a: assert property (o_cmd_start != 16'h0000 |-> // [RL1]
        $onehot(o_cmd_start) && st_ff == scs_pkg::SCS_RUN && tmr_ff == cmd_len(cur_ff))
        else $error("command start malformed");
    flag_clear_a: assert property ((clr_flags && set_bits == 16'h0000) |=> // [RL11]
        (o_status & 16'h7F7F) == 16'h0000)
        else $error("flags survive clear");
    alarm_hold_a: assert property ((i_alarm_hit != 7'h00) |=> // [RL12]
        (o_status[14:8] & $past(i_alarm_hit)) == $past(i_alarm_hit))
        else $error("alarm flag not recorded");
    frame_fail_a: assert property (frame_bad |=> // [RL14]
        o_status[3] ##1 o_status[3] || $past(clr_flags))
        else $error("bad frame not flagged");
    escape_flag_a: assert property (esc_evt |=> o_status[4] && o_rec_escape) // [RL17]
        else $error("escape not flagged");
    checksum_flag_a: assert property ((fin_ftest && i_checksum_fail) |=> o_status[6]) // [RL16]
        else $error("checksum failure not flagged");
    supply_flag_a: assert property ((i_supply_high || i_supply_low) |=> // [RL18]
        (o_status[1] || !$past(i_supply_high)) && (o_status[0] || !$past(i_supply_low)))
        else $error("supply flag not set");
    selftest_len_a: assert property ((o_cmd_start[2]) |-> tmr_ff == TW'(CYC_SELF)) // [RL10]
        else $error("self-test length wrong");

endmodule

// ---- scs_cfg.svh ----
// constants of the system command and status register group
// assumes a 40 MHz system clock and 16-bit serial words
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
`define SCS_CLK_NS        25
`define SCS_CYC(ns)       (((ns) + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
// register byte addresses
`define SCS_A_FLASH       7'h00
`define SCS_A_DIO         7'h36
`define SCS_A_GPIO        7'h38
`define SCS_A_STAT        7'h3C
`define SCS_A_CMD         7'h3E
`define SCS_A_LOT1        7'h52
`define SCS_A_LOT2        7'h54
`define SCS_A_PROD        7'h56
`define SCS_A_SER         7'h58
// serial word fields
`define SCS_W_WR          15
`define SCS_W_ESC         8'hE8
`define SCS_W_LAST        4'hF
// command bits
`define SCS_C_SELF        2
`define SCS_C_FACT        3
`define SCS_C_CLRST       4
`define SCS_C_FTEST       5
// status bits
`define SCS_S_VLO         0
`define SCS_S_VHI         1
`define SCS_S_FLASH       2
`define SCS_S_SPI         3
`define SCS_S_ESC         4
`define SCS_S_SELF        5
`define SCS_S_CHK         6
`define SCS_S_RDY         7
`define SCS_S_ALM         8
`define SCS_S_UNUSED      15
// execution times in ns
`define SCS_T_NULCLR_NS   35000
`define SCS_T_ALMGET_NS   40000
`define SCS_T_RESTORE_NS  1900000
`define SCS_T_ALMSAV_NS   461000
`define SCS_T_PTR_NS      36000
`define SCS_T_ALMERA_NS   25800000
`define SCS_T_CLRREC_NS   25900000
`define SCS_T_SWRST_NS    53300000
`define SCS_T_SAVE_NS     29300000
`define SCS_T_FTEST_NS    5600000
`define SCS_T_CLRST_NS    36000
`define SCS_T_FACT_NS     80900000
`define SCS_T_SELF_NS     32900000
`define SCS_T_AUTONUL_NS  681000000
`endif

// ---- scs_pkg.sv ----
// types of the system command and status register group
// assumes nothing beyond the constants header
package scs_pkg;
    typedef enum logic [0:0] {
        SCS_IDLE = 1'b0,
        SCS_RUN  = 1'b1
    } scs_state_t;
    typedef logic [15:0] scs_word_t;
endpackage

// ---- scs_host.sv ----
// serial host model standing on the far side of the register group
// assumes the device samples data on the rising serial clock edge and
// shifts read data out on the falling edge; 64 ns serial period
`timescale 1ns/1ps

module scs_host (
    // serial port towards the device
    output logic            o_sclk,
    output logic            o_cs_b,
    output logic            o_din,
    input  wire logic       i_dout
);
    initial begin
        o_sclk = 1'b1;
        o_cs_b = 1'b1;
        o_din  = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////////
    // one frame of n clocks; the clock stands high outside frames
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
        rd = 16'h0000;
        o_cs_b = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            o_sclk = 1'b0;
            o_din  = w[15-i];
            #32;
            o_sclk = 1'b1;
            rd = {rd[14:0], i_dout};
            #32;
        end
        #40;
        o_cs_b = 1'b1;
        // deselected data line must not keep showing the last bit
        o_din = ~o_din;
        // gap well above the 8 system clocks the device needs between frames
        #400;
    endtask
endmodule

// ---- tb_system_command_status_regs.sv ----
// self-checking bench for the system command and status register group
// assumes eight command lengths shortened to 40 cycles; band fetch, status clear and the rest keep full length
`timescale 1ns/1ps

module tb_system_command_status_regs;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        i_rec_active = 1'b0;
    logic        i_rec_start = 1'b0;
    logic [6:0]  i_alarm_hit = 7'h00;
    logic        i_checksum_fail = 1'b0;
    logic        i_selftest_fail = 1'b0;
    logic        i_flash_fail = 1'b0;
    logic        i_supply_high = 1'b0;
    logic        i_supply_low = 1'b0;
    logic        sclk, cs_b, din, dout, o_rec_escape, seen_esc;
    logic [15:0] o_cmd_start, o_status, dio, gpio, seen_start;
    int          n_fail = 0;
    int          check_count = 0;
    logic        i_ce = 1'b1;
    logic [15:0] fcnt = 16'h1234, lot_a = 16'h2B4D, lot_b = 16'h3C5E, pcode = 16'h4D6F;
    logic [15:0] serno = 16'h5E70;
    localparam int SHORT = 40;

    always #12.5 i_clk = ~i_clk;

    scs_host i_host (.o_sclk(sclk), .o_cs_b(cs_b), .o_din(din), .i_dout(dout));

    scs_regs #(.CYC_RESTORE(SHORT), .CYC_ALMSAV(SHORT), .CYC_ALMERA(SHORT),
        .CYC_CLRREC(SHORT), .CYC_SAVE(SHORT), .CYC_FTEST(SHORT), .CYC_FACT(SHORT),
        .CYC_SELF(SHORT)) i_dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_sclk(sclk), .i_cs_b(cs_b),
        .i_din(din), .o_dout(dout), .i_rec_active(i_rec_active),
        .i_rec_start(i_rec_start), .i_alarm_hit(i_alarm_hit),
        .i_checksum_fail(i_checksum_fail), .i_selftest_fail(i_selftest_fail),
        .i_flash_fail(i_flash_fail), .i_supply_high(i_supply_high),
        .i_supply_low(i_supply_low), .i_flash_write_count(fcnt),
        .i_lot_code_one(lot_a), .i_lot_code_two(lot_b), .i_product_code(pcode),
        .i_unit_serial(serno), .o_cmd_start(o_cmd_start), .o_rec_escape(o_rec_escape),
        .o_status(o_status), .o_digital_io_config(dio), .o_general_io_control(gpio));

    // pulses last one cycle, so they are caught here and judged later
    always @(posedge i_clk) begin
        seen_start <= seen_start | o_cmd_start;
        seen_esc   <= seen_esc | o_rec_escape;
    end

    //////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] w);
        logic [15:0] rd;
        i_host.xfer(w, 16, rd);
    endtask

    task automatic rdreg(input logic [6:0] a, output logic [15:0] v);
        logic [15:0] rd;
        i_host.xfer({1'b0, a, 8'h00}, 16, rd);
        i_host.xfer(16'h0000, 16, v);
    endtask

    // n counts the cycles still busy after the write frame ends
    task automatic run_cmd(input int b, output int n);
        logic [15:0] w;
        w = (b > 7) ? (16'hBF00 | (16'h0001 << (b - 8))) : (16'hBE00 | (16'h0001 << b));
        @(negedge i_clk);
        seen_start = 16'h0000;
        wr(w);
        chk(seen_start, 16'h0001 << b);
        n = 0;
        while (o_status[7] !== 1'b1 && n < 2000) begin
            @(negedge i_clk);
            n++;
        end
    endtask

    //////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [15:0] v;
        chk(o_status, 16'h0080);
        rdreg(7'h3C, v);
        chk(v, 16'h0080);
        wr({1'b1, 7'h3C, 8'hFF});
        wr({1'b1, 7'h36, 8'h5A});
        wr({1'b1, 7'h37, 8'hA5});
        rdreg(7'h36, v);
        chk(v, 16'hA55A);
        wr({1'b1, 7'h38, 8'h3C});
        wr({1'b1, 7'h39, 8'hC3});
        rdreg(7'h38, v);
        chk(v, 16'hC33C);
        chk(gpio, 16'hC33C);
        rdreg(7'h3E, v);
        chk(v, 16'h0000);
        rdreg(7'h20, v);
        chk(v, 16'h0000);
        rdreg(7'h00, v);
        chk(v, 16'h1234);
        rdreg(7'h52, v);
        chk(v, lot_a);
        rdreg(7'h54, v);
        chk(v, lot_b);
        rdreg(7'h56, v);
        chk(v, pcode);
        rdreg(7'h58, v);
        chk(v, serno);
        chk(o_status, 16'h0080);
    endtask

    task automatic t_cmds;
        int bits[7] = '{14, 13, 12, 9, 8, 6, 3};
        int ln[7] = '{40000 / 25, SHORT, SHORT, SHORT, SHORT, SHORT, SHORT};
        int n;
        foreach (bits[i]) begin
            run_cmd(bits[i], n);
            // ready returns about 15 cycles short of the command length after the frame; allow four either way
            chk(16'((n + 15 - ln[i]) / 5), 16'h0000);
        end
        chk(dio, 16'h0000);
        chk(gpio, 16'h0000);
    endtask

    task automatic t_diag;
        int n;
        i_selftest_fail = 1'b1;
        i_checksum_fail = 1'b1;
        run_cmd(2, n);
        repeat (2) @(negedge i_clk);
        chk(o_status, 16'h00A0);
        run_cmd(5, n);
        repeat (2) @(negedge i_clk);
        chk(o_status, 16'h00E0);
        i_selftest_fail = 1'b0;
        i_checksum_fail = 1'b0;
    endtask

    task automatic t_alarms;
        logic [6:0] e;
        e = 7'h00;
        for (int k = 0; k < 7; k++) begin
            @(negedge i_clk);
            i_alarm_hit = 7'h01 << k;
            @(negedge i_clk);
            i_alarm_hit = 7'h00;
            e = e | (7'h01 << k);
            repeat (3) @(negedge i_clk);
            chk({9'h000, o_status[14:8]}, {9'h000, e});
        end
        // a frozen block must ignore the recording start
        i_ce        = 1'b0;
        i_rec_start = 1'b1;
        repeat (2) @(negedge i_clk);
        chk(o_status, 16'h7FE0);
        i_ce = 1'b1;
        @(negedge i_clk);
        i_rec_start = 1'b0;
        repeat (3) @(negedge i_clk);
        chk(o_status, 16'h0080);
    endtask

    task automatic t_errors;
        logic [15:0] rd;
        int n;
        @(negedge i_clk);
        i_supply_high = 1'b1;
        i_supply_low  = 1'b1;
        i_flash_fail  = 1'b1;
        @(negedge i_clk);
        i_flash_fail = 1'b0;
        i_host.xfer(16'h0000, 15, rd);
        chk(o_status & 16'h000F, 16'h000F);
        @(negedge i_clk);
        i_supply_high = 1'b0;
        i_supply_low  = 1'b0;
        i_rec_active  = 1'b1;
        seen_esc      = 1'b0;
        repeat (3) @(negedge i_clk);
        chk(16'(o_status[7]), 16'h0000);
        wr(16'hE800);
        chk(16'(seen_esc), 16'h0001);
        chk(o_status, 16'h001F);
        @(negedge i_clk);
        i_rec_active = 1'b0;
        run_cmd(4, n);
        repeat (2) @(negedge i_clk);
        chk(o_status, 16'h0080);
    endtask

    //////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        seen_start = 16'h0000;
        seen_esc   = 1'b0;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        i_rst_b = 1'b1;
        repeat (4) @(negedge i_clk);
        t_regs();
        t_cmds();
        t_diag();
        t_alarms();
        t_errors();
        tally_and_finish();
    end

    // the whole run needs well under half of this span
    initial begin
        #2_000_000;
        n_fail++;
        tally_and_finish();
    end
endmodule
